/* logic/vmpc_map.svh */
`ifndef VMPC_MAP_SVH
`define VMPC_MAP_SVH

// register indices; byte address is four times the index
`define VMPC_IDX_POH_SEL 10'h012
`define VMPC_IDX_TRACE_CTL 10'h013
`define VMPC_IDX_ALARM_CTL 10'h014
`define VMPC_IDX_STATUS 10'h060
`define VMPC_IDX_CNT0 10'h062
`define VMPC_IDX_POH_RAM_BASE 10'h068
`define VMPC_IDX_TRACE_BASE 10'h100

// sizes
`define VMPC_POH_RAM_WORDS 8
`define VMPC_TRACE_WORDS 64

// reset values
`define VMPC_RST_POH_SEL 8'h00
`define VMPC_RST_TRACE_CTL 8'h08
`define VMPC_RST_ALARM_CTL 8'h00

// alarm control field positions
`define VMPC_BIT_EXT_LOS_AIS_EN 7
`define VMPC_BIT_TX_CLK_LOSS_AIS_EN 6

// status field positions
`define VMPC_BIT_STAT_AIS 7
`define VMPC_BIT_STAT_PTR_PIN 6

// line alarm pattern and axi responses
`define VMPC_AIS_BYTE 8'hFF
`define VMPC_RESP_OKAY 2'h0
`define VMPC_RESP_SLVERR 2'h2

`endif

/* logic/vmpc_pkg.sv */
package vmpc_pkg;

	// transmit path overhead byte identity; order matches select bits
	typedef enum logic [2:0] {
		VMPC_POH_J1,
		VMPC_POH_C2,
		VMPC_POH_G1,
		VMPC_POH_F2,
		VMPC_POH_H4,
		VMPC_POH_Z3,
		VMPC_POH_Z4,
		VMPC_POH_Z5
	} vmpc_poh_e;

	typedef struct packed {
		logic trace_compare_mode;
		logic trace_memory_size_sel;
		logic tx_unequipped;
		logic overhead_to_ram;
		logic rx_line_tristate;
		logic line_loopback;
		logic network_payload_loopback;
		logic counter_wrap_mode;
	} vmpc_trace_ctl_s;

	typedef struct packed {
		logic valid;
		vmpc_poh_e id;
		logic [7:0] data;
	} vmpc_poh_s;

endpackage : vmpc_pkg

/* logic/vmpc_perf_cnt.sv */
`timescale 1ns/1ps
`default_nettype none

module vmpc_perf_cnt
	import vmpc_pkg::*;
#(
	parameter int WIDTH = 16
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// control
	input wire logic inc,
	input wire logic rd_clr,
	input wire logic wrap_mode,
	// value
	output logic [WIDTH-1:0] count
);

	logic [WIDTH-1:0] cnt_reg;
	localparam logic [WIDTH-1:0] CNT_MAX = '1;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			cnt_reg <= '0;
		else if (rd_clr && !wrap_mode)
			// an event in the clearing cycle is kept
			cnt_reg <= inc ? {{(WIDTH-1){1'b0}}, 1'b1} : '0;
		else if (inc)
		begin
			if (cnt_reg != CNT_MAX)
				cnt_reg <= cnt_reg + 1'b1;
			else if (wrap_mode)
				cnt_reg <= '0;
			else
				cnt_reg <= CNT_MAX;
		end
	end

	assign count = cnt_reg;

endmodule : vmpc_perf_cnt

`default_nettype wire

/* logic/vmpc_ctrl.sv */
// Summary of operation
// - Z5/Z4/Z3: external byte or RAM 6F/6E/6D
// - H4/F2/C2: external byte or RAM 6C/6B/69
// - G1: external byte or internal logic
// - J1: external byte or processor value
// - size bit: trace segments 16 or 64
// - received trace stored cyclically, no start
// - unequipped with insert-disable pin high: overhead and payload sent zero
// - supervisory unequipped: overhead normal, payload zero
// - capture on: external overhead written to RAM
// - capture off: RAM keeps processor values
// - tristate bit floats receive data and clock
// - tristate bit is one after reset
// - line loopback; receive outputs still driven
// - payload loopback, invalid while tracking pin high
// - wrap mode: counters roll over to zero
// - saturate mode: counters hold, clear on read
// - loss-of-signal pin low sends AIS if enabled
// - transmit clock loss sends AIS if enabled
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "vmpc_map.svh"

module vmpc_ctrl
	import vmpc_pkg::*;
#(
	parameter int CNT_WIDTH = 16,
	parameter int N_CNT = 2
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// axi4-lite write address and data
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// device pins, asynchronous
	input wire logic ext_loss_of_signal_in,
	input wire logic pointer_tracking_enable_pin,
	input wire logic overhead_insert_disable_pin,
	// transmit overhead request and result
	input wire vmpc_poh_s tx_poh_req,
	input wire logic [7:0] ext_poh_byte,
	input wire logic [7:0] g1_internal_byte,
	output vmpc_poh_s tx_poh_out,
	// payload
	input wire logic payload_valid,
	input wire logic [7:0] payload_in,
	input wire logic [7:0] drop_payload_in,
	output logic payload_out_valid,
	output logic [7:0] payload_out,
	output logic network_loopback_active,
	// line side
	input wire logic [7:0] tx_line_data_in,
	input wire logic [7:0] rx_line_data_in,
	input wire logic rx_line_clock_in,
	input wire logic tx_clock_loss_alarm,
	output logic [7:0] tx_line_data_out,
	output logic tx_ais_active,
	output logic [7:0] rx_line_data_out,
	output logic rx_line_data_oe,
	output logic rx_line_clock_out,
	output logic rx_line_clock_oe,
	// received trace bytes
	input wire logic rx_trace_valid,
	input wire logic [7:0] rx_trace_byte,
	// performance events
	input wire logic [N_CNT-1:0] perf_event
);

	function automatic logic [9:0] vmpc_index(input logic [11:0] addr);
		vmpc_index = addr[11:2];
	endfunction : vmpc_index

	// control registers
	logic [7:0] poh_sel_reg;
	vmpc_trace_ctl_s trace_ctl_reg;
	logic ext_los_ais_enable_reg;
	logic tx_clock_loss_ais_enable_reg;

	// memories
	logic [7:0] poh_ram [`VMPC_POH_RAM_WORDS];
	logic [7:0] trace_ram [`VMPC_TRACE_WORDS];
	logic [5:0] trace_ptr_reg;

	// bus state
	logic aw_taken_reg;
	logic w_taken_reg;
	logic [9:0] aw_idx_reg;
	logic [7:0] wdata_reg;
	logic wlane0_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	// pin synchronisers
	logic [2:0] pin_async;
	logic [2:0] pin_meta_reg;
	logic [2:0] pin_sync_reg;
	logic los_n_sync;
	logic ptr_pin_sync;
	logic ohd_pin_sync;

	assign pin_async = {overhead_insert_disable_pin, pointer_tracking_enable_pin, ext_loss_of_signal_in};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			always_ff @(posedge sys_clk)
			begin
				if (rst)
				begin
					pin_meta_reg[gi] <= 1'b0;
					pin_sync_reg[gi] <= 1'b0;
				end
				else
				begin
					pin_meta_reg[gi] <= pin_async[gi];
					pin_sync_reg[gi] <= pin_meta_reg[gi];
				end
			end
		end
	endgenerate

	assign los_n_sync = pin_sync_reg[0];
	assign ptr_pin_sync = pin_sync_reg[1];
	assign ohd_pin_sync = pin_sync_reg[2];

	// axi write channel
	logic wr_do;
	logic [9:0] ar_idx;
	logic ar_hs;
	logic wr_hit_ctl;
	logic wr_hit_poh_ram;
	logic wr_hit;

	assign s_axi_awready = !aw_taken_reg && !bvalid_reg;
	assign s_axi_wready = !w_taken_reg && !bvalid_reg;
	assign wr_do = aw_taken_reg && w_taken_reg && !bvalid_reg;
	// the status word carries the writable supervisory unequipped bit
	assign wr_hit_ctl = (aw_idx_reg == `VMPC_IDX_POH_SEL) || (aw_idx_reg == `VMPC_IDX_TRACE_CTL) ||
		(aw_idx_reg == `VMPC_IDX_ALARM_CTL) || (aw_idx_reg == `VMPC_IDX_STATUS);
	assign wr_hit_poh_ram = (aw_idx_reg[9:3] == 7'(`VMPC_IDX_POH_RAM_BASE >> 3));
	assign wr_hit = wr_hit_ctl || wr_hit_poh_ram;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			aw_taken_reg <= 1'b0;
			w_taken_reg <= 1'b0;
			aw_idx_reg <= '0;
			wdata_reg <= '0;
			wlane0_reg <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_taken_reg <= 1'b1;
				aw_idx_reg <= vmpc_index(s_axi_awaddr);
			end
			else if (wr_do)
				aw_taken_reg <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_taken_reg <= 1'b1;
				wdata_reg <= s_axi_wdata[7:0];
				wlane0_reg <= s_axi_wstrb[0];
			end
			else if (wr_do)
				w_taken_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg <= `VMPC_RESP_OKAY;
		end
		else if (wr_do)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_hit ? `VMPC_RESP_OKAY : `VMPC_RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_reg <= 1'b0;
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// control register writes
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			poh_sel_reg <= `VMPC_RST_POH_SEL;
			trace_ctl_reg <= `VMPC_RST_TRACE_CTL;
			ext_los_ais_enable_reg <= 1'b0;
			tx_clock_loss_ais_enable_reg <= 1'b0;
		end
		else if (wr_do && wlane0_reg)
		begin
			if (aw_idx_reg == `VMPC_IDX_POH_SEL)
				poh_sel_reg <= wdata_reg;
			else if (aw_idx_reg == `VMPC_IDX_TRACE_CTL)
				trace_ctl_reg <= wdata_reg;
			else if (aw_idx_reg == `VMPC_IDX_ALARM_CTL)
			begin
				ext_los_ais_enable_reg <= wdata_reg[`VMPC_BIT_EXT_LOS_AIS_EN];
				tx_clock_loss_ais_enable_reg <= wdata_reg[`VMPC_BIT_TX_CLK_LOSS_AIS_EN];
			end
		end
	end

	// transmit overhead selection
	logic poh_ext_sel;
	logic poh_capture;
	logic unequip_active;
	logic payload_zero;
	logic [7:0] poh_byte_next;

	assign poh_ext_sel = poh_sel_reg[tx_poh_req.id];
	// the device relies on the insert pin being high while unequipped
	assign unequip_active = trace_ctl_reg.tx_unequipped && ohd_pin_sync;
	assign payload_zero = unequip_active;
	assign poh_capture = tx_poh_req.valid && poh_ext_sel && trace_ctl_reg.overhead_to_ram;

	always_comb
	begin
		if (poh_ext_sel)
			poh_byte_next = ext_poh_byte;
		else if (tx_poh_req.id == VMPC_POH_G1)
			poh_byte_next = g1_internal_byte;
		else
			poh_byte_next = poh_ram[tx_poh_req.id];
	end

	// supervisory unequipped sits in bit 0 of the status word
	logic supervisory_unequipped_reg;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			supervisory_unequipped_reg <= 1'b0;
		else if (wr_do && wlane0_reg && aw_idx_reg == `VMPC_IDX_STATUS)
			supervisory_unequipped_reg <= wdata_reg[0];
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			tx_poh_out <= '0;
		else
		begin
			tx_poh_out.valid <= tx_poh_req.valid;
			tx_poh_out.id <= tx_poh_req.id;
			if (unequip_active && !supervisory_unequipped_reg)
				tx_poh_out.data <= 8'h00;
			else
				tx_poh_out.data <= poh_byte_next;
		end
	end

	// processor writes and external capture share the overhead ram
	always_ff @(posedge sys_clk)
	begin
		if (poh_capture)
			poh_ram[tx_poh_req.id] <= ext_poh_byte;
		else if (wr_do && wlane0_reg && wr_hit_poh_ram)
			poh_ram[aw_idx_reg[2:0]] <= wdata_reg;
	end

	// payload path
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			payload_out_valid <= 1'b0;
			payload_out <= '0;
		end
		else
		begin
			payload_out_valid <= payload_valid;
			if (payload_zero)
				payload_out <= 8'h00;
			else if (network_loopback_active)
				payload_out <= drop_payload_in;
			else
				payload_out <= payload_in;
		end
	end

	// loopback is suppressed while pointer tracking is on
	assign network_loopback_active = trace_ctl_reg.network_payload_loopback && !ptr_pin_sync;

	// line side
	logic ais_next;

	assign ais_next = (ext_los_ais_enable_reg && !los_n_sync) ||
		(tx_clock_loss_ais_enable_reg && tx_clock_loss_alarm);

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			tx_ais_active <= 1'b0;
			tx_line_data_out <= '0;
		end
		else
		begin
			tx_ais_active <= ais_next;
			if (ais_next)
				tx_line_data_out <= `VMPC_AIS_BYTE;
			else if (trace_ctl_reg.line_loopback)
				tx_line_data_out <= rx_line_data_in;
			else
				tx_line_data_out <= tx_line_data_in;
		end
	end

	// receive outputs keep running during line loopback
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			rx_line_data_out <= '0;
			rx_line_clock_out <= 1'b0;
		end
		else
		begin
			rx_line_data_out <= rx_line_data_in;
			rx_line_clock_out <= rx_line_clock_in;
		end
	end

	assign rx_line_data_oe = !trace_ctl_reg.rx_line_tristate;
	assign rx_line_clock_oe = !trace_ctl_reg.rx_line_tristate;

	// received trace capture; both compare modes use the rotating store
	logic [5:0] trace_ptr_inc;

	assign trace_ptr_inc = trace_ptr_reg + 6'd1;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			trace_ptr_reg <= '0;
		else if (rx_trace_valid)
		begin
			if (trace_ctl_reg.trace_memory_size_sel)
				trace_ptr_reg <= {2'b00, trace_ptr_inc[3:0]};
			else
				trace_ptr_reg <= trace_ptr_inc;
		end
		else if (trace_ctl_reg.trace_memory_size_sel)
			trace_ptr_reg <= {2'b00, trace_ptr_reg[3:0]};
	end

	always_ff @(posedge sys_clk)
	begin
		if (rx_trace_valid)
			trace_ram[trace_ptr_reg] <= rx_trace_byte;
	end

	// performance counters
	logic [CNT_WIDTH-1:0] cnt_val [N_CNT];
	logic [N_CNT-1:0] cnt_rd_clr;

	generate
		for (gi = 0; gi < N_CNT; gi++)
		begin : g_cnt
			assign cnt_rd_clr[gi] = ar_hs && (ar_idx == `VMPC_IDX_CNT0 + 10'(gi));
			vmpc_perf_cnt #(
				.WIDTH(CNT_WIDTH)
			) u_cnt (
				.sys_clk(sys_clk),
				.rst(rst),
				.inc(perf_event[gi]),
				.rd_clr(cnt_rd_clr[gi]),
				.wrap_mode(trace_ctl_reg.counter_wrap_mode),
				.count(cnt_val[gi])
			);
		end
	endgenerate

	// axi read channel
	logic [31:0] rd_mux;
	logic rd_hit;

	assign s_axi_arready = !rvalid_reg;
	assign ar_hs = s_axi_arvalid && s_axi_arready;
	assign ar_idx = vmpc_index(s_axi_araddr);

	always_comb
	begin
		rd_mux = '0;
		rd_hit = 1'b1;
		if (ar_idx == `VMPC_IDX_POH_SEL)
			rd_mux[7:0] = poh_sel_reg;
		else if (ar_idx == `VMPC_IDX_TRACE_CTL)
			rd_mux[7:0] = trace_ctl_reg;
		else if (ar_idx == `VMPC_IDX_ALARM_CTL)
		begin
			rd_mux[`VMPC_BIT_EXT_LOS_AIS_EN] = ext_los_ais_enable_reg;
			rd_mux[`VMPC_BIT_TX_CLK_LOSS_AIS_EN] = tx_clock_loss_ais_enable_reg;
		end
		else if (ar_idx == `VMPC_IDX_STATUS)
		begin
			rd_mux[0] = supervisory_unequipped_reg;
			rd_mux[`VMPC_BIT_STAT_AIS] = tx_ais_active;
			rd_mux[`VMPC_BIT_STAT_PTR_PIN] = ptr_pin_sync;
			rd_mux[13:8] = trace_ptr_reg;
		end
		else if (ar_idx >= `VMPC_IDX_CNT0 && ar_idx < `VMPC_IDX_CNT0 + 10'(N_CNT))
			rd_mux[CNT_WIDTH-1:0] = cnt_val[ar_idx[0]];
		else if (ar_idx[9:3] == 7'(`VMPC_IDX_POH_RAM_BASE >> 3))
			rd_mux[7:0] = poh_ram[ar_idx[2:0]];
		else if (ar_idx[9:6] == 4'(`VMPC_IDX_TRACE_BASE >> 6))
			rd_mux[7:0] = trace_ram[ar_idx[5:0]];
		else
			rd_hit = 1'b0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= `VMPC_RESP_OKAY;
		end
		else if (ar_hs)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_mux;
			rresp_reg <= rd_hit ? `VMPC_RESP_OKAY : `VMPC_RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_reg <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

endmodule : vmpc_ctrl

`default_nettype wire

/* verif/vmpc_ctrl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vmpc_map.svh"
module vmpc_ctrl_assertions
	import vmpc_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// overhead and payload
	input wire vmpc_poh_s tx_poh_req,
	input wire vmpc_poh_s tx_poh_out,
	input wire logic payload_valid,
	input wire logic [7:0] payload_in,
	input wire logic payload_out_valid,
	input wire logic [7:0] payload_out,
	// pins and line
	input wire logic overhead_insert_disable_pin,
	input wire logic pointer_tracking_enable_pin,
	input wire logic network_loopback_active,
	input wire logic tx_ais_active,
	input wire logic [7:0] tx_line_data_out,
	input wire logic [7:0] rx_line_data_in,
	input wire logic rx_line_clock_in,
	input wire logic [7:0] rx_line_data_out,
	input wire logic rx_line_clock_out,
	input wire logic rx_line_data_oe,
	input wire logic rx_line_clock_oe
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	sequence poh_taken;
		tx_poh_req.valid;
	endsequence
	oe_pair_a: assert property (rx_line_data_oe == rx_line_clock_oe)
		else $error("receive enables differ");
	oe_reset_a: assert property ($past(rst) |-> !rx_line_data_oe && !rx_line_clock_oe)
		else $error("receive outputs driven after reset");
	rx_pipe_a: assert property (!$past(rst) |-> rx_line_data_out == $past(rx_line_data_in)
		&& rx_line_clock_out == $past(rx_line_clock_in))
		else $error("receive outputs not following line");
	poh_answer_a: assert property (poh_taken |=> tx_poh_out.valid && tx_poh_out.id == $past(tx_poh_req.id))
		else $error("overhead answer missing");
	poh_idle_a: assert property (!tx_poh_req.valid |=> !tx_poh_out.valid)
		else $error("overhead answer without request");
	ais_data_a: assert property (tx_ais_active |-> tx_line_data_out == `VMPC_AIS_BYTE)
		else $error("alarm pattern not sent");
	loop_pin_a: assert property (network_loopback_active |-> !$past(pointer_tracking_enable_pin, 2))
		else $error("loopback while tracking");
	payload_pass_a: assert property (payload_valid && !network_loopback_active
		&& !$past(overhead_insert_disable_pin, 2) |=> payload_out_valid && payload_out == $past(payload_in))
		else $error("payload altered with insertion off");
endmodule : vmpc_ctrl_assertions
bind vmpc_ctrl vmpc_ctrl_assertions chk_i (.*);
`default_nettype wire

/* verif/vmpc_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module vmpc_ctrl_tb
	import vmpc_pkg::*;
;
	logic sys_clk = 0, rst = 1;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic ext_loss_of_signal_in = 1, pointer_tracking_enable_pin = 0, overhead_insert_disable_pin = 0;
	vmpc_poh_s tx_poh_req = '0, tx_poh_out;
	logic [7:0] ext_poh_byte = 0, g1_internal_byte = 0, payload_in = 0, drop_payload_in = 0, payload_out;
	logic payload_valid = 0, payload_out_valid, network_loopback_active, rx_trace_valid = 0;
	logic [7:0] tx_line_data_in = 0, rx_line_data_in = 0, tx_line_data_out, rx_line_data_out, rx_trace_byte = 0;
	logic rx_line_clock_in = 0, tx_clock_loss_alarm = 0, tx_ais_active;
	logic rx_line_data_oe, rx_line_clock_out, rx_line_clock_oe;
	logic [1:0] perf_event = 0;
	int num_errors = 0, checks = 0;
	logic [31:0] seed = 32'h0000_003c, rd;
	logic [1:0] rs;
	logic [7:0] sel, ram [8];
	logic [5:0] p0;
	logic [7:0] tx_exp, last_byte;
	// short counters so saturation is reached quickly
	vmpc_ctrl #(.CNT_WIDTH(4)) uut (.*);
	initial forever #2 sys_clk = ~sys_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [7:0] poh_exp(input int id, input logic z);
		if (z)
			return 8'h00;
		if (sel[id])
			return ext_poh_byte;
		return id == 2 ? g1_internal_byte : ram[id];
	endfunction : poh_exp
	task automatic end_sim();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// one write or one read, each channel held until its own handshake
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_arvalid <= !w;
		s_axi_bready <= w;
		s_axi_rready <= !w;
		do
		begin
			@(posedge sys_clk);
			n++;
			if (s_axi_awready)
				s_axi_awvalid <= 0;
			if (s_axi_wready)
				s_axi_wvalid <= 0;
			if (s_axi_arready)
				s_axi_arvalid <= 0;
		end while (!(s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready) && n < 60);
		rd = s_axi_rdata;
		rs = w ? s_axi_bresp : s_axi_rresp;
		s_axi_bready <= 0;
		s_axi_rready <= 0;
		if (n >= 60)
		begin
			num_errors++;
			end_sim();
		end
	endtask : bus
	task automatic poh(input int id, input logic z, input logic cap);
		@(posedge sys_clk);
		tx_poh_req <= '{1'b1, vmpc_poh_e'(id), 8'h00};
		ext_poh_byte <= 8'(rnd());
		g1_internal_byte <= 8'(rnd());
		@(posedge sys_clk);
		tx_poh_req.valid <= 0;
		#1;
		`CHK("poh", poh_exp(id, z), tx_poh_out.data);
		if (cap && sel[id])
			ram[id] = ext_poh_byte;
	endtask : poh
	task automatic pay(input logic z, input logic lb);
		@(posedge sys_clk);
		payload_valid <= 1;
		payload_in <= 8'(rnd());
		drop_payload_in <= 8'(rnd());
		@(posedge sys_clk);
		payload_valid <= 0;
		#1;
		`CHK("payload", z ? 8'h00 : lb ? drop_payload_in : payload_in, payload_out);
	endtask : pay
	task automatic ev(input int n);
		repeat (n) @(posedge sys_clk) perf_event <= 2'h3;
		@(posedge sys_clk) perf_event <= 2'h0;
	endtask : ev
	initial
	begin
		repeat (4) @(posedge sys_clk);
		rst <= 0;
		bus(0, 12'h04c, 0);
		`CHK("trace_ctl", 8'h08, rd);
		`CHK("oe", 0, rx_line_data_oe);
		bus(0, 12'h048, 0);
		`CHK("poh_sel", 0, rd);
		bus(0, 12'h050, 0);
		`CHK("alarm_ctl", 0, rd);
		bus(0, 12'h7fc, 0);
		`CHK("unmapped", 2'h2, rs);
		for (int i = 0; i < 8; i++)
		begin
			ram[i] = 8'(rnd());
			bus(1, 12'(('h68 + i) * 4), ram[i]);
		end
		// corner selections none-external and all-external among random ones
		for (int p = 0; p < 4; p++)
		begin
			sel = p == 1 ? 8'h00 : p == 2 ? 8'hff : 8'(rnd());
			bus(1, 12'h048, sel);
			bus(1, 12'h04c, p[0] ? 32'h10 : 32'h0);
			`CHK("oe_on", 1, rx_line_data_oe);
			for (int i = 0; i < 8; i++)
				poh(i, 0, p[0]);
			for (int i = 0; i < 8; i++)
			begin
				bus(0, 12'(('h68 + i) * 4), 0);
				`CHK("poh_ram", ram[i], rd);
			end
		end
		for (int j = 0; j < 8; j++)
		begin
			overhead_insert_disable_pin <= j[2];
			bus(1, 12'h180, j[1]);
			`CHK("sup_resp", 2'h0, rs);
			bus(1, 12'h04c, j[0] ? 32'h20 : 32'h0);
			pay(j[0] & j[2], 0);
			poh(1, j[0] & j[2] & !j[1], 0);
		end
		bus(1, 12'h04c, 32'h2);
		for (int q = 0; q < 2; q++)
		begin
			pointer_tracking_enable_pin <= q[0];
			repeat (3) @(posedge sys_clk);
			#1;
			`CHK("net_loop", !q[0], network_loopback_active);
			pay(0, !q[0]);
		end
		for (int k = 0; k < 16; k++)
		begin
			bus(1, 12'h050, 32'({k[0], k[1], 6'h00}));
			bus(1, 12'h04c, k[2] ? 32'h4 : 32'h0);
			ext_loss_of_signal_in <= !k[2];
			tx_clock_loss_alarm <= k[3];
			rx_line_clock_in <= !rx_line_clock_in;
			rx_line_data_in <= 8'(rnd());
			tx_line_data_in <= 8'(rnd());
			repeat (4) @(posedge sys_clk);
			#1;
			`CHK("ais", k[0] & k[2] | k[1] & k[3], tx_ais_active);
			tx_exp = (k[0] & k[2] | k[1] & k[3]) ? 8'hff : k[2] ? rx_line_data_in : tx_line_data_in;
			`CHK("tx_line", tx_exp, tx_line_data_out);
			`CHK("rx_line", rx_line_data_in, rx_line_data_out);
		end
		bus(1, 12'h04c, 32'h0);
		bus(0, 12'h188, 0);
		ev(5);
		bus(0, 12'h188, 0);
		`CHK("cnt", 5, rd);
		bus(0, 12'h188, 0);
		`CHK("cnt_clr", 0, rd);
		ev(20);
		bus(0, 12'h188, 0);
		`CHK("cnt_sat", 15, rd);
		bus(0, 12'h18c, 0);
		`CHK("cnt1_sat", 15, rd);
		bus(1, 12'h04c, 32'h1);
		ev(20);
		for (int r = 0; r < 3; r++)
		begin
			bus(0, r < 2 ? 12'h188 : 12'h18c, 0);
			`CHK("cnt_wrap", 4, rd);
		end
		for (int s = 0; s < 2; s++)
		begin
			bus(1, 12'h04c, s[0] ? 32'h40 : 32'h0);
			bus(0, 12'h180, 0);
			p0 = rd[13:8];
			repeat (20) @(posedge sys_clk)
			begin
				last_byte = 8'(rnd());
				rx_trace_valid <= 1;
				rx_trace_byte <= last_byte;
			end
			@(posedge sys_clk) rx_trace_valid <= 0;
			bus(0, 12'h180, 0);
			`CHK("trace_ptr", (p0 + 20) % (s[0] ? 16 : 64), rd[13:8]);
			bus(0, 12'h400 + 12'(((p0 + 19) % (s[0] ? 16 : 64)) * 4), 0);
			`CHK("trace_ram", last_byte, rd);
		end
		end_sim();
	end
endmodule : vmpc_ctrl_tb
`default_nettype wire
